/* sram_port_cfg.svh */
/*
  Constants of the burst-of-four double-data-rate SRAM port: widths, burst
  geometry, byte lanes and reset values.
  Assumes it is included by bare name, before any user of these macros.
*/
`ifndef SRAM_PORT_CFG_SVH
`define SRAM_PORT_CFG_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define ADDR_W     17
`define BEAT_W     2
`define WADDR_W    19
`define WORD_W     18
`define BURST_LEN  4
`define MEM_DEPTH  524288

// ----------------------------------------
// Byte lanes
// ----------------------------------------
`define LO_MSB     8
`define HI_LSB     9
`define HI_MSB     17

// ----------------------------------------
// Word slots within a burst
// ----------------------------------------
`define SLOT_0     2'h0
`define SLOT_1     2'h1
`define SLOT_2     2'h2
`define SLOT_3     2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SYNC_RST_VAL 1'h0
`define MODE_K_RST   1'h1

`endif

/* sram_port_pkg.sv */
/*
  Types of the SRAM port: burst phase enum and the packed state structs of
  every clock domain.
  Assumes sram_port_cfg.svh is on the include path.
*/
`include "sram_port_cfg.svh"

package sram_port_pkg;

  typedef logic [`WORD_W-1:0] word_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_FIRST  = 2'b01,
    PH_SECOND = 2'b10
  } burst_phase_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync3_s;

  typedef struct packed {
    logic                ignore;
    burst_phase_e        phase;
    logic [`ADDR_W-1:0]  base;
  } seq_s;

  typedef struct packed {
    word_t [`BURST_LEN-1:0] rd_buf;
    logic                   q_k_valid;
    word_t                  q_k_data;
    logic                   kn_rd_valid;
    word_t                  kn_rd_data;
    logic                   kn_wr_valid;
    logic [`WADDR_W-1:0]    kn_wr_addr;
    logic                   mode_k;
    logic                   rd_busy;
    logic                   wr_busy;
  } kdom_s;

  typedef struct packed {
    logic  q_valid;
    word_t q_data;
    word_t hold_data;
    logic  hold_lo_n;
    logic  hold_hi_n;
  } kndom_s;

  typedef struct packed {
    logic  q_valid;
    word_t q_data;
  } cdom_s;

endpackage

/* sync3.sv */
/*
  Three-stage level synchroniser; the output moves once stages two and three
  agree.
  Assumes d is a level from another clock domain.
*/
`timescale 1ns/1ps
`include "sram_port_cfg.svh"

module sync3 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  sram_port_pkg::sync3_s st_r;
  sram_port_pkg::sync3_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.level = st_r.s3;
    end
    if (!rst_n) begin
      st_nxt = {4{`SYNC_RST_VAL}};
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign q = st_r.level;

endmodule // sync3

/* burst_seq.sv */
/*
  One burst sequencer: launches on a low select, steps two true-clock phases
  carrying the four word slots, drops a back-to-back request.
  Assumes clk is the true input clock and rst_n is already in its domain.
*/
`timescale 1ns/1ps
`include "sram_port_cfg.svh"

module burst_seq (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       select_n,
  input  wire logic                       block,
  input  wire logic [`ADDR_W-1:0]         addr_in,
  output logic                            launch,
  output sram_port_pkg::burst_phase_e     phase,
  output logic [`ADDR_W-1:0]              base
);

  sram_port_pkg::seq_s st_r;
  sram_port_pkg::seq_s st_nxt;

  // Select is dead for one edge after it launched
  assign launch = !select_n && !st_r.ignore && !block;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.ignore = launch;
    case (st_r.phase)
      sram_port_pkg::PH_FIRST: begin
        st_nxt.phase = sram_port_pkg::PH_SECOND;
      end
      default: begin
        st_nxt.phase = sram_port_pkg::PH_IDLE;
      end
    endcase
    if (launch) begin
      st_nxt.phase = sram_port_pkg::PH_FIRST;
      st_nxt.base  = addr_in;
    end
    if (!rst_n) begin
      st_nxt = '0;
    end
  end

  // Only the true clock advances the sequencer
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign phase = st_r.phase;
  assign base  = st_r.base;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_back_to_back: assert property (@(posedge clk) disable iff (!rst_n) launch |=> !launch)
    else $error("select accepted on edge right after a launch");
  a_burst_order: assert property (@(posedge clk) disable iff (!rst_n)
    launch |=> phase == sram_port_pkg::PH_FIRST ##1 phase == sram_port_pkg::PH_SECOND)
    else $error("burst phases out of order");
  a_addr_ignored: assert property (@(posedge clk) disable iff (!rst_n) !launch |=> base == $past(base))
    else $error("address taken without a launch");
  a_block_wins: assert property (@(posedge clk) disable iff (!rst_n) block |-> !launch)
    else $error("launch while blocked");

endmodule // burst_seq

/* burst4_ddr_sram_port.sv */
/*
  Device side of a burst-of-four SRAM with separate double-data-rate read and
  write ports on one shared address bus, with its storage array.
  Assumes the controller drives the true/complement input clock pair and
  optionally the output clock pair; core_clk only watches burst activity.
*/
// Operation
// - Address gains two internal low word bits
// - Burst steps base plus zero to three
// - Read and write sequencers run independently
// - A read launch blocks a write launch on the same edge
// - Sequencers advance on true clock rise only
// - Write words captured K, K#, K, K#
// - Read words presented C, C#, C, C#
// - Output clocks both high: time from K
// - Read data driven only for read commands
// - Write data captured on both input edges
// - Select ignored on edge after its launch
// - Low and high byte enables per edge
// - Address ignored without a launch
// - Four eighteen-bit words per burst
`timescale 1ns/1ps
`include "sram_port_cfg.svh"

module burst4_ddr_sram_port (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 k_clk,
  input  wire logic                 k_n_clk,
  input  wire logic                 c_clk,
  input  wire logic                 c_n_clk,
  input  wire logic                 read_select_n,
  input  wire logic                 write_select_n,
  input  wire logic [`ADDR_W-1:0]   shared_address_in,
  input  wire logic                 byte_write_lo_n,
  input  wire logic                 byte_write_hi_n,
  input  wire logic [`WORD_W-1:0]   write_data_in,
  output logic      [`WORD_W-1:0]   read_data_out,
  output logic                      read_data_oe,
  output logic                      read_busy,
  output logic                      write_busy
);

  localparam sram_port_pkg::kdom_s  K_RST  = '{mode_k: `MODE_K_RST, default: '0};

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  logic [`WORD_W-1:0] mem [0:`MEM_DEPTH-1];

  sram_port_pkg::kdom_s  k_r;
  sram_port_pkg::kdom_s  k_nxt;
  sram_port_pkg::kndom_s kn_r;
  sram_port_pkg::kndom_s kn_nxt;
  sram_port_pkg::cdom_s  c_r;
  sram_port_pkg::cdom_s  c_nxt;
  sram_port_pkg::cdom_s  cn_r;
  sram_port_pkg::cdom_s  cn_nxt;

  logic                                     link_rstn;
  logic                                     c_held;
  logic                                     cn_held;
  logic                                     rd_launch;
  logic                                     wr_launch;
  sram_port_pkg::burst_phase_e              rd_phase;
  sram_port_pkg::burst_phase_e              wr_phase;
  logic [`ADDR_W-1:0]                       rd_base;
  logic [`ADDR_W-1:0]                       wr_base;
  logic [`WADDR_W-1:0]                      wr_now_addr;
  sram_port_pkg::word_t [`BURST_LEN-1:0]    rd_fetch;

  // ----------------------------------------
  // Reset and output-clock detection in the link domain
  // ----------------------------------------
  // The device has no reset pin of its own; the core reset is carried over
  sync3 u_rst_sync (
    .clk   (k_clk),
    .rst_n (1'b1),
    .d     (rstn),
    .q     (link_rstn)
  );

  // A running output clock pair is never high on both at one sample
  sync3 u_c_sync (
    .clk   (k_clk),
    .rst_n (link_rstn),
    .d     (c_clk),
    .q     (c_held)
  );

  sync3 u_cn_sync (
    .clk   (k_clk),
    .rst_n (link_rstn),
    .d     (c_n_clk),
    .q     (cn_held)
  );

  // ----------------------------------------
  // Burst sequencers
  // ----------------------------------------
  // Separate instances so a read and a write can overlap
  burst_seq u_rd_seq (
    .clk      (k_clk),
    .rst_n    (link_rstn),
    .select_n (read_select_n),
    .block    (1'b0),
    .addr_in  (shared_address_in),
    .launch   (rd_launch),
    .phase    (rd_phase),
    .base     (rd_base)
  );

  burst_seq u_wr_seq (
    .clk      (k_clk),
    .rst_n    (link_rstn),
    .select_n (write_select_n),
    .block    (rd_launch),
    .addr_in  (shared_address_in),
    .launch   (wr_launch),
    .phase    (wr_phase),
    .base     (wr_base)
  );

  // ----------------------------------------
  // Array access
  // ----------------------------------------
  // All four read words are fetched at launch, so a later write cannot tear
  // a burst already in flight
  genvar gi;
  generate
    for (gi = 0; gi < `BURST_LEN; gi = gi + 1) begin : g_fetch
      assign rd_fetch[gi] = mem[{shared_address_in, 2'(gi)}];
    end
  endgenerate

  always_comb begin
    if (wr_phase == sram_port_pkg::PH_SECOND) begin
      wr_now_addr = {wr_base, `SLOT_2};
    end else begin
      wr_now_addr = {wr_base, `SLOT_0};
    end
  end

  // True-edge words go straight in; complement-edge words wait a half period
  always_ff @(posedge k_clk) begin
    if (wr_phase != sram_port_pkg::PH_IDLE) begin
      if (!byte_write_lo_n) begin
        mem[wr_now_addr][`LO_MSB:0] <= write_data_in[`LO_MSB:0];
      end
      if (!byte_write_hi_n) begin
        mem[wr_now_addr][`HI_MSB:`HI_LSB] <= write_data_in[`HI_MSB:`HI_LSB];
      end
    end
    if (k_r.kn_wr_valid) begin
      if (!kn_r.hold_lo_n) begin
        mem[k_r.kn_wr_addr][`LO_MSB:0] <= kn_r.hold_data[`LO_MSB:0];
      end
      if (!kn_r.hold_hi_n) begin
        mem[k_r.kn_wr_addr][`HI_MSB:`HI_LSB] <= kn_r.hold_data[`HI_MSB:`HI_LSB];
      end
    end
  end

  // ----------------------------------------
  // True input clock domain
  // ----------------------------------------
  always_comb begin
    k_nxt             = k_r;
    k_nxt.q_k_valid   = 1'b0;
    k_nxt.kn_rd_valid = 1'b0;
    k_nxt.kn_wr_valid = 1'b0;
    if (rd_launch) begin
      k_nxt.rd_buf = rd_fetch;
    end
    case (rd_phase)
      sram_port_pkg::PH_FIRST: begin
        k_nxt.q_k_valid   = 1'b1;
        k_nxt.q_k_data    = k_r.rd_buf[`SLOT_0];
        k_nxt.kn_rd_valid = 1'b1;
        k_nxt.kn_rd_data  = k_r.rd_buf[`SLOT_1];
      end
      sram_port_pkg::PH_SECOND: begin
        k_nxt.q_k_valid   = 1'b1;
        k_nxt.q_k_data    = k_r.rd_buf[`SLOT_2];
        k_nxt.kn_rd_valid = 1'b1;
        k_nxt.kn_rd_data  = k_r.rd_buf[`SLOT_3];
      end
      default: begin
      end
    endcase
    case (wr_phase)
      sram_port_pkg::PH_FIRST: begin
        k_nxt.kn_wr_valid = 1'b1;
        k_nxt.kn_wr_addr  = {wr_base, `SLOT_1};
      end
      sram_port_pkg::PH_SECOND: begin
        k_nxt.kn_wr_valid = 1'b1;
        k_nxt.kn_wr_addr  = {wr_base, `SLOT_3};
      end
      default: begin
      end
    endcase
    k_nxt.mode_k  = c_held && cn_held;
    k_nxt.rd_busy = rd_launch || (rd_phase == sram_port_pkg::PH_FIRST);
    k_nxt.wr_busy = wr_launch || (wr_phase == sram_port_pkg::PH_FIRST);
    if (!link_rstn) begin
      k_nxt = K_RST;
    end
  end

  // No edge, no change: a stopped clock pair freezes every burst
  always_ff @(posedge k_clk) begin
    k_r <= k_nxt;
  end

  // ----------------------------------------
  // Complement input clock domain
  // ----------------------------------------
  always_comb begin
    kn_nxt         = kn_r;
    kn_nxt.q_valid = k_r.kn_rd_valid;
    kn_nxt.q_data  = k_r.kn_rd_data;
    if (k_r.kn_wr_valid) begin
      kn_nxt.hold_data = write_data_in;
      kn_nxt.hold_lo_n = byte_write_lo_n;
      kn_nxt.hold_hi_n = byte_write_hi_n;
    end
    if (!link_rstn) begin
      kn_nxt = '0;
    end
  end

  always_ff @(posedge k_n_clk) begin
    kn_r <= kn_nxt;
  end

  // ----------------------------------------
  // Output clock domains
  // ----------------------------------------
  // Output clocks run at the input rate with a lag under half a period
  always_comb begin
    c_nxt.q_valid  = k_r.q_k_valid;
    c_nxt.q_data   = k_r.q_k_data;
    cn_nxt.q_valid = kn_r.q_valid;
    cn_nxt.q_data  = kn_r.q_data;
    if (!link_rstn) begin
      c_nxt  = '0;
      cn_nxt = '0;
    end
  end

  always_ff @(posedge c_clk) begin
    c_r <= c_nxt;
  end

  always_ff @(posedge c_n_clk) begin
    cn_r <= cn_nxt;
  end

  // Double-rate pin: the high phase of a clock shows its rise word
  always_comb begin
    if (k_r.mode_k) begin
      read_data_out = k_clk ? k_r.q_k_data : kn_r.q_data;
      read_data_oe  = k_clk ? k_r.q_k_valid : kn_r.q_valid;
    end else begin
      read_data_out = c_clk ? c_r.q_data : cn_r.q_data;
      // Output pair still held while detection settles: c_r never clocked, keep floating
      read_data_oe  = (c_clk ? c_r.q_valid : cn_r.q_valid) && !(c_clk && c_n_clk);
    end
  end

  // ----------------------------------------
  // Core clock status
  // ----------------------------------------
  sync3 u_rd_busy_sync (
    .clk   (core_clk),
    .rst_n (rstn),
    .d     (k_r.rd_busy),
    .q     (read_busy)
  );

  sync3 u_wr_busy_sync (
    .clk   (core_clk),
    .rst_n (rstn),
    .d     (k_r.wr_busy),
    .q     (write_busy)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_read_first: assert property (@(posedge k_clk) disable iff (!link_rstn) rd_launch |-> !wr_launch)
    else $error("write launched together with a read");
  a_write_slots: assert property (@(posedge k_clk) disable iff (!link_rstn)
    wr_launch |-> ##2 (k_r.kn_wr_valid && k_r.kn_wr_addr == {$past(shared_address_in, 2), `SLOT_1})
    ##1 (k_r.kn_wr_valid && k_r.kn_wr_addr[1:0] == `SLOT_3))
    else $error("write complement slots wrong");
  a_read_slots: assert property (@(posedge k_clk) disable iff (!link_rstn)
    rd_launch |-> ##2 (k_r.q_k_valid && k_r.kn_rd_valid) [*2])
    else $error("read burst not presented over two periods");
  a_read_source: assert property (@(posedge k_clk) disable iff (!link_rstn)
    k_r.q_k_valid |-> ($past(rd_launch, 2) || $past(rd_launch, 3)))
    else $error("read data without a read command");
  a_idle_float: assert property (@(posedge k_clk) disable iff (!link_rstn)
    (rd_phase == sram_port_pkg::PH_IDLE) |=> !k_r.q_k_valid && !k_r.kn_rd_valid)
    else $error("output enabled with no read slot");
  a_mode_follow: assert property (@(posedge k_clk) disable iff (!link_rstn)
    $rose(c_held && cn_held) |=> k_r.mode_k)
    else $error("held output clocks not detected");
  a_hold_capture: assert property (@(posedge k_n_clk) disable iff (!link_rstn)
    k_r.kn_wr_valid |=> kn_r.hold_data == $past(write_data_in))
    else $error("complement edge write word not captured");

  c_read_burst: cover property (@(posedge k_clk) disable iff (!link_rstn) rd_launch ##2 rd_launch);
  c_write_burst: cover property (@(posedge k_clk) disable iff (!link_rstn) wr_launch ##2 wr_launch);
  c_overlap: cover property (@(posedge k_clk) disable iff (!link_rstn)
    rd_phase != sram_port_pkg::PH_IDLE && wr_phase != sram_port_pkg::PH_IDLE);
  c_k_timed: cover property (@(posedge k_clk) disable iff (!link_rstn) k_r.mode_k && k_r.q_k_valid);

endmodule // burst4_ddr_sram_port

/* mem_ctrl_model.sv */
/*
  Memory controller model on the far side of the SRAM port: makes the input
  and output clock pairs, drives commands, address, byte enables and write
  data from queues the bench fills, and captures read words.
  Assumes the bench pushes one command per true-clock edge, in order.
*/
`timescale 1ns/1ps
`include "sram_port_cfg.svh"

module mem_ctrl_model (
  output logic                 k_clk,
  output logic                 k_n_clk,
  output logic                 c_clk,
  output logic                 c_n_clk,
  output logic                 read_select_n,
  output logic                 write_select_n,
  output logic [`ADDR_W-1:0]   shared_address_in,
  output logic                 byte_write_lo_n,
  output logic                 byte_write_hi_n,
  output logic [`WORD_W-1:0]   write_data_in,
  input  wire logic [`WORD_W-1:0] read_data_out,
  input  wire logic            read_data_oe
);
  // Command: {read_select_n, write_select_n, data_follows, address}
  logic [19:0]          q_cmd [$];
  logic [`WORD_W+1:0]   wd_q [$];
  logic [`WORD_W-1:0]   rd_q [$];
  logic                 cmode = 1'b0;
  int                   hold_ns = 0;
  int                   pend = 0;
  int                   arm = 0;
  logic [19:0]          cmd;

  // ----------------------------------------
  // Data edges
  // ----------------------------------------
  task automatic data_edge();
    if (pend > 0) begin
      {byte_write_hi_n, byte_write_lo_n, write_data_in} <= wd_q.pop_front();
      pend--;
    end else begin
      // Released lines keep changing so a stale word never looks valid
      {byte_write_hi_n, byte_write_lo_n, write_data_in} <= ~{byte_write_hi_n, byte_write_lo_n, write_data_in};
    end
  endtask

  task automatic sample();
    if (read_data_oe === 1'b1) rd_q.push_back(read_data_out);
  endtask

  // ----------------------------------------
  // Clock pairs and command slots
  // ----------------------------------------
  initial begin
    k_clk = 1'b0;
    k_n_clk = 1'b1;
    {read_select_n, write_select_n} = 2'h3;
    shared_address_in = '0;
    {byte_write_hi_n, byte_write_lo_n, write_data_in} = '0;
    forever begin
      if (hold_ns > 0) begin
        #(hold_ns);
        hold_ns = 0;
      end
      k_clk = 1'b1;
      k_n_clk = 1'b0;
      data_edge();
      // Word 0 goes out half a period before the edge after the launch edge
      pend += arm;
      cmd = (q_cmd.size() > 0) ? q_cmd.pop_front() : {3'h6, ~shared_address_in};
      {read_select_n, write_select_n} <= cmd[19:18];
      shared_address_in <= cmd[16:0];
      arm = cmd[17] ? 4 : 0;
      #18 sample();
      #6;
      k_clk = 1'b0;
      k_n_clk = 1'b1;
      data_edge();
      #18 sample();
      #6;
    end
  end

  // Output pair lags the input pair; held high selects input-pair timing
  initial c_clk = 1'b1;
  initial c_n_clk = 1'b1;
  always @(k_clk) c_clk <= #6 (cmode ? k_clk : 1'b1);
  always @(k_n_clk) c_n_clk <= #6 (cmode ? k_n_clk : 1'b1);
endmodule // mem_ctrl_model

/* tb_top.sv */
/*
  Self-checking bench of the SRAM port: a queue model predicts launches,
  drops and read words; the controller model drives the link.
  Assumes mem_ctrl_model and the design are compiled before it.
*/
`timescale 1ns/1ps
`include "sram_port_cfg.svh"

module tb_top;
  logic                 core_clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 k_clk, k_n_clk, c_clk, c_n_clk;
  logic                 read_select_n, write_select_n;
  logic [`ADDR_W-1:0]   shared_address_in;
  logic                 byte_write_lo_n, byte_write_hi_n;
  logic [`WORD_W-1:0]   write_data_in, read_data_out;
  logic                 read_data_oe, read_busy, write_busy;
  logic [`WORD_W-1:0]   mem [int];
  logic [`WORD_W-1:0]   exp_q [$];
  logic [`ADDR_W-1:0]   addrs [8];
  logic [7:0]           be_tab [4] = '{8'hE4, 8'h39, 8'h4E, 8'h93};
  logic                 pr = 1'b0, pw = 1'b0, seen_rb = 1'b0, seen_wb = 1'b0;
  int                   seed = 37, miscompares = 0, cmp_count = 0, i, n;

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (read_busy === 1'b1) seen_rb <= 1'b1;
    if (write_busy === 1'b1) seen_wb <= 1'b1;
  end

  mem_ctrl_model u_ctrl (.k_clk(k_clk), .k_n_clk(k_n_clk), .c_clk(c_clk), .c_n_clk(c_n_clk),
    .read_select_n(read_select_n), .write_select_n(write_select_n), .shared_address_in(shared_address_in),
    .byte_write_lo_n(byte_write_lo_n), .byte_write_hi_n(byte_write_hi_n), .write_data_in(write_data_in),
    .read_data_out(read_data_out), .read_data_oe(read_data_oe));
  burst4_ddr_sram_port u_dut (.core_clk(core_clk), .rstn(rstn), .k_clk(k_clk), .k_n_clk(k_n_clk),
    .c_clk(c_clk), .c_n_clk(c_n_clk), .read_select_n(read_select_n), .write_select_n(write_select_n),
    .shared_address_in(shared_address_in), .byte_write_lo_n(byte_write_lo_n),
    .byte_write_hi_n(byte_write_hi_n), .write_data_in(write_data_in), .read_data_out(read_data_out),
    .read_data_oe(read_data_oe), .read_busy(read_busy), .write_busy(write_busy));

  // ----------------------------------------
  // Model and checks
  // ----------------------------------------
  task automatic check(input string what, input logic [`WORD_W-1:0] exp, input logic [`WORD_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One command per true-clock edge; be holds {hi_n, lo_n} per word
  task automatic issue(input logic [1:0] kind, input logic [`ADDR_W-1:0] a, input logic [7:0] be);
    logic                 rl, wl;
    logic [`WORD_W-1:0]   w, m;
    int                   j;
    rl = kind[0] && !pr;
    wl = kind[1] && !pw && !rl;
    for (j = 0; j < 4; j++) begin
      if (rl) exp_q.push_back(mem[{a, j[1:0]}]);
    end
    for (j = 0; j < 4 && wl; j++) begin
      w = $random(seed);
      m = {{9{~be[2*j+1]}}, {9{~be[2*j]}}};
      mem[{a, j[1:0]}] = (mem[{a, j[1:0]}] & ~m) | (w & m);
      u_ctrl.wd_q.push_back({be[2*j +: 2], w});
    end
    u_ctrl.q_cmd.push_back({~kind[0], ~kind[1], wl, a});
    pr = rl;
    pw = wl;
  endtask

  task automatic nops(input int cnt);
    for (int j = 0; j < cnt; j++) issue(2'h0, $random(seed), 8'h00);
  endtask

  task automatic flush(input string name);
    for (n = 0; n < 2000 && u_ctrl.q_cmd.size() != 0; n++) @(posedge k_clk);
    repeat (6) @(posedge k_clk);
    pr = 1'b0;
    pw = 1'b0;
    check({name, " count"}, 18'(exp_q.size()), 18'(u_ctrl.rd_q.size()));
    while (exp_q.size() > 0 && u_ctrl.rd_q.size() > 0) check(name, exp_q.pop_front(), u_ctrl.rd_q.pop_front());
    exp_q.delete();
    u_ctrl.rd_q.delete();
    $display("test %s done", name);
  endtask

  task final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    $display("ERROR watchdog expected done seen hang");
    final_report();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    // Held past the link clock's reset synchroniser
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge k_clk);
    for (i = 0; i < 8; i++) begin
      addrs[i] = $random(seed);
      issue(2'h2, addrs[i], 8'h00);
      nops(1);
    end
    for (i = 0; i < 8; i++) begin
      issue(2'h1, addrs[i], 8'h00);
      nops(1);
    end
    flush("write_read");
    check("write_busy seen", 18'h1, {17'h0, seen_wb});
    check("read_busy seen", 18'h1, {17'h0, seen_rb});
    for (i = 0; i < 4; i++) begin
      issue(2'h2, addrs[i], be_tab[i]);
      nops(1);
    end
    nops(2);
    for (i = 0; i < 4; i++) begin
      issue(2'h1, addrs[i], 8'h00);
      nops(1);
    end
    flush("byte_lanes");
    issue(2'h2, addrs[4], 8'h00);
    issue(2'h2, addrs[5], 8'h00);
    nops(4);
    issue(2'h1, addrs[5], 8'h00);
    issue(2'h1, addrs[4], 8'h00);
    nops(1);
    issue(2'h3, addrs[6], 8'h00);
    issue(2'h2, addrs[6], 8'h00);
    nops(4);
    issue(2'h1, addrs[6], 8'h00);
    nops(1);
    issue(2'h1, addrs[4], 8'h00);
    flush("drop_and_overlap");
    issue(2'h1, addrs[7], 8'h00);
    nops(3);
    for (n = 0; n < 100 && u_ctrl.q_cmd.size() > 2; n++) begin
      @(posedge k_clk);
      #1;
    end
    u_ctrl.hold_ns = 500;
    flush("clock_stop");
    u_ctrl.cmode = 1'b1;
    nops(8);
    for (i = 0; i < 8; i++) begin
      issue(2'h1, addrs[i], 8'h00);
      nops(1);
    end
    flush("c_mode");
    repeat (10) @(posedge core_clk);
    check("read_busy idle", 18'h0, {17'h0, read_busy});
    check("write_busy idle", 18'h0, {17'h0, write_busy});
    final_report();
  end
endmodule // tb_top
